// ---- rtl/mmd_pkg.sv ----
// Shared constants and types for the memory-map decode block
package mmd_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] PC_WRAP = 16'h3FFF;
  localparam logic [15:0] FLASH_SIZE = 16'h4000;
  localparam logic [15:0] SMALL_APP_LIMIT = 16'h2000;
  localparam logic [15:0] SMALL_DF_START = 16'h3000;
  localparam logic [15:0] PAGE_MASK = 16'hFF80;
  localparam logic [15:0] BOOT_FLASH_SIZE = 16'h0800;
  localparam logic [15:0] BOOT_FLASH_BASE = 16'h4000;
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_DFBASE = 8'h9C;
  localparam logic [7:0] SFR_GUARD = 8'hC7;
  localparam logic [7:0] SFR_PSW = 8'hD0;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] DFBASE_RESET = 8'h00;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] GUARD_KEY1 = 8'hAA;
  localparam logic [7:0] GUARD_KEY2 = 8'h55;
  localparam int PSW_RS_LSB = 3;
  localparam int CFG_DF_ENABLE_BIT = 0;
  localparam logic [1:0] INIT_CYCLES = 2'h3;
  localparam int GUARD_WINDOW_NS = 32;
  localparam int GUARD_WINDOW_CYCLES = GUARD_WINDOW_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    K_DIRECT, K_INDIRECT, K_REG, K_BIT, K_XDPTR, K_XRI, K_PUSH, K_POP
  } mmd_kind_e;

  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_CALL_HI} mmd_state_e;
endpackage

// ---- rtl/mmd_mem_if.sv ----
// Byte-wide memory port between the decoder and a RAM
`timescale 1ns/1ps
interface mmd_mem_if;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// ---- rtl/mmd_ram.sv ----
// 256-byte RAM with combinational read and clocked write
`timescale 1ns/1ps
module mmd_ram (
  input wire logic sys_clk,
  mmd_mem_if.mem port
);
  logic [7:0] mem [256];

  assign port.rdata = mem[port.addr];

  always_ff @(posedge sys_clk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
  end
endmodule

// ---- rtl/mmd_flash_map.sv ----
// Partition of the shared flash into program and data regions
`timescale 1ns/1ps
module mmd_flash_map
  import mmd_pkg::*;
(
  input wire logic [7:0] base_high,
  input wire logic df_enable_cfg,
  input wire logic small_variant,
  output logic [15:0] app_limit,
  output logic [15:0] df_start
);
  always_comb begin
    if (small_variant) begin
      app_limit = SMALL_APP_LIMIT;
      df_start = df_enable_cfg ? FLASH_SIZE : SMALL_DF_START; // [R09]
    end else if (df_enable_cfg) begin
      app_limit = FLASH_SIZE; // [R10]
      df_start = FLASH_SIZE;
    end else begin
      df_start = {base_high, 8'h00}; // [R05]
      app_limit = {base_high, 8'h00}; // [R07]
    end
  end
endmodule

// ---- rtl/mmd_decode.sv ----
// Memory-map decode: fetch mapping, data-space routing, stack and flash partition
`timescale 1ns/1ps
// How it works
// R01: Erase always clears one aligned 128-byte page; nothing finer.
// R02: Booting from application flash, fetching starts at 0000H.
// R03: Fetches beyond application flash return NOP; counter wraps 3FFFH to 0000H.
// R04: Boot-loader flash is remapped to appear at 0000H with all vectors.
// R05: Data-flash start is base register as high byte, low byte 00H.
// R06: Every reset reloads the base register from the second configuration byte.
// R07: Changing the base moves the boundary between application and data flash.
// R08: Base register writes only land inside an open timed-access window.
// R09: Small variant fixes data flash at 3000H-3FFFH, or none (start 4000H) when the enable bit is 1; base register ignored.
// R10: Enable bit at 1 gives application the whole 16K on the full variant; small variant keeps 2000H; base ignored.
// R11: Configuration erase allowed from boot loader or external writers.
// R12: Auxiliary RAM decodes 256 bytes, reached only by external moves.
// R13: Stack pushes and pops always target scratch-pad RAM.
// R14: Special registers answer direct addressing only; scratch-pad answers both.
// R15: Four banks of eight registers; two status bits pick the active one.
// R16: Registers zero and one of active bank serve as indirect pointers.
// R17: Scratch-pad bytes 20h-2Fh allow whole-byte and single-bit access.
// R18: Bit versus byte access follows the instruction type only.
// R19: Special registers at addresses ending 0 or 8 allow bit access.
// R20: Stack pointer resets to 07h and is freely writable after.
// R21: Push increments then stores; pop reads then decrements.
// R22: Calls and interrupt entries push the return address onto the stack.
// R23: Register operand maps to bank times eight plus register index.
module mmd_decode
  import mmd_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] config_byte_first,
  input wire logic [7:0] config_byte_second,
  input wire logic boot_select_bit,
  input wire logic ext_writer_active,
  input wire logic fetch_step,
  input wire logic pc_load,
  input wire logic [15:0] pc_load_value,
  output logic [15:0] prog_counter,
  output logic [15:0] fetch_phys_addr,
  output logic fetch_nop,
  output logic fetch_boot,
  input wire logic acc_req,
  input wire mmd_kind_e acc_kind,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic acc_we,
  output logic acc_done,
  output logic [7:0] acc_rdata,
  output logic acc_bit,
  input wire logic call_req,
  input wire logic [15:0] call_ret_addr,
  input wire logic erase_req,
  input wire logic [15:0] erase_addr,
  input wire logic erase_config,
  output logic erase_go,
  output logic [15:0] erase_page_base,
  output logic erase_refused,
  output logic [15:0] df_start_addr,
  output logic [15:0] app_limit_addr
);
  logic [17:0] sync1, sync2;
  logic [7:0] cfg1_s, cfg2_s;
  logic boot_s, ext_s;
  logic [1:0] init_cnt;
  logic [7:0] sp, program_status_word, df_base, ptr_q, wdata_q, ret_hi_q;
  logic we_q, guard_armed;
  logic [2:0] guard_cnt;
  logic guard_open;
  mmd_kind_e kind_q, cur_kind;
  mmd_state_e state;
  logic [15:0] next_pc, map_app_limit, map_df_start;
  logic [7:0] cur_addr, cur_wdata, sfr_a, sfr_rd, byte_rd, wr_byte, data_a, sfr_wd;
  logic [1:0] bank;
  logic [2:0] bit_idx;
  logic cur_we, go, fin, need_ptr, sfr_hit, x_sel, use_rmw;
  logic sp_up, sp_down, sfr_wr;

  mmd_mem_if sp_bus ();
  mmd_mem_if xr_bus ();

  mmd_ram u_scratch (.sys_clk(sys_clk), .port(sp_bus.mem));
  mmd_ram u_aux (.sys_clk(sys_clk), .port(xr_bus.mem)); // [R12]

  mmd_flash_map u_map (
    .base_high(df_base),
    .df_enable_cfg(cfg1_s[CFG_DF_ENABLE_BIT]),
    .small_variant(SMALL_VARIANT),
    .app_limit(map_app_limit),
    .df_start(map_df_start)
  );

  // Two-stage synchronisers for straps and configuration levels
  generate
    for (genvar i = 0; i < 18; i++) begin : g_sync
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          sync1[i] <= 1'b0;
          sync2[i] <= 1'b0;
        end else begin
          sync1[i] <= (i < 8) ? config_byte_first[i % 8] :
                      (i < 16) ? config_byte_second[i % 8] :
                      (i == 16) ? boot_select_bit : ext_writer_active;
          sync2[i] <= sync1[i];
        end
      end
    end
  endgenerate

  assign cfg1_s = sync2[7:0];
  assign cfg2_s = sync2[15:8];
  assign boot_s = sync2[16];
  assign ext_s = sync2[17];
  assign bank = program_status_word[PSW_RS_LSB +: 2]; // [R15]
  assign guard_open = (guard_cnt != 3'h0);

  // Program counter advance with wrap at the top of the flash
  always_comb begin
    next_pc = prog_counter;
    if (pc_load) begin
      next_pc = pc_load_value;
    end else if (fetch_step) begin
      next_pc = (prog_counter == PC_WRAP) ? RESET_VECTOR : prog_counter + 16'h0001; // [R03]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prog_counter <= RESET_VECTOR; // [R02]
      fetch_phys_addr <= RESET_VECTOR;
      fetch_nop <= 1'b0;
      fetch_boot <= 1'b0;
    end else begin
      prog_counter <= next_pc;
      fetch_boot <= boot_s;
      if (boot_s) begin
        fetch_phys_addr <= BOOT_FLASH_BASE + {5'h00, next_pc[10:0]}; // [R04]
        fetch_nop <= (next_pc >= BOOT_FLASH_SIZE);
      end else begin
        fetch_phys_addr <= next_pc;
        fetch_nop <= (next_pc >= map_app_limit); // [R03]
      end
    end
  end

  // Select the live request when idle, the latched one afterwards
  always_comb begin
    go = (state == ST_IDLE && acc_req && !call_req) || state == ST_ACCESS;
    cur_kind = (state == ST_ACCESS) ? kind_q : acc_kind;
    cur_addr = (state == ST_ACCESS) ? ptr_q : acc_addr;
    cur_wdata = (state == ST_ACCESS) ? wdata_q : acc_wdata;
    cur_we = (state == ST_ACCESS) ? we_q : acc_we;
  end

  // Address decode: routes each access to scratch-pad, auxiliary RAM or registers
  always_comb begin
    sp_bus.addr = 8'h00;
    sp_bus.we = 1'b0;
    data_a = cur_wdata;
    xr_bus.addr = cur_addr;
    xr_bus.we = 1'b0;
    sfr_hit = 1'b0;
    sfr_a = cur_addr;
    bit_idx = 3'h0;
    fin = 1'b0;
    need_ptr = 1'b0;
    x_sel = 1'b0;
    use_rmw = 1'b0;
    if (state == ST_CALL_HI) begin
      sp_bus.addr = sp + 8'h01; // [R22]
      sp_bus.we = 1'b1;
      data_a = ret_hi_q;
      fin = 1'b1;
    end else if (state == ST_IDLE && call_req) begin
      sp_bus.addr = sp + 8'h01; // [R22]
      sp_bus.we = 1'b1;
      data_a = call_ret_addr[7:0];
    end else if (go) begin
      case (cur_kind)
        K_DIRECT: begin
          fin = 1'b1;
          if (cur_addr[7]) begin
            sfr_hit = 1'b1; // [R14]
          end else begin
            sp_bus.addr = cur_addr;
            sp_bus.we = cur_we;
          end
        end
        K_INDIRECT, K_XRI: begin
          if (state == ST_IDLE) begin
            need_ptr = 1'b1;
            sp_bus.addr = {3'h0, bank, 2'h0, acc_addr[0]}; // [R16]
          end else if (cur_kind == K_XRI) begin
            x_sel = 1'b1; // [R12]
            xr_bus.we = cur_we;
            fin = 1'b1;
          end else begin
            sp_bus.addr = cur_addr; // [R14]
            sp_bus.we = cur_we;
            fin = 1'b1;
          end
        end
        K_REG: begin
          sp_bus.addr = {3'h0, bank, cur_addr[2:0]}; // [R23]
          sp_bus.we = cur_we;
          fin = 1'b1;
        end
        K_BIT: begin
          bit_idx = cur_addr[2:0]; // [R18]
          use_rmw = 1'b1;
          fin = 1'b1;
          if (cur_addr[7]) begin
            sfr_hit = 1'b1;
            sfr_a = {cur_addr[7:3], 3'h0}; // [R19]
          end else begin
            sp_bus.addr = BIT_RAM_BASE + {4'h0, cur_addr[6:3]}; // [R17]
            sp_bus.we = cur_we;
          end
        end
        K_XDPTR: begin
          x_sel = 1'b1; // [R12]
          xr_bus.we = cur_we;
          fin = 1'b1;
        end
        K_PUSH: begin
          sp_bus.addr = sp + 8'h01; // [R21] [R13]
          sp_bus.we = 1'b1;
          fin = 1'b1;
        end
        K_POP: begin
          sp_bus.addr = sp; // [R21] [R13]
          fin = 1'b1;
        end
        default: fin = 1'b1;
      endcase
    end
  end

  always_comb begin
    case (sfr_a)
      SFR_SP: sfr_rd = sp;
      SFR_PSW: sfr_rd = program_status_word;
      SFR_DFBASE: sfr_rd = df_base;
      default: sfr_rd = 8'h00;
    endcase
    byte_rd = sfr_hit ? sfr_rd : (x_sel ? xr_bus.rdata : sp_bus.rdata);
    wr_byte = byte_rd;
    wr_byte[bit_idx] = cur_wdata[0];
    sp_bus.wdata = use_rmw ? wr_byte : data_a;
    xr_bus.wdata = cur_wdata;
    sfr_wd = use_rmw ? wr_byte : cur_wdata;
    sp_up = (state == ST_IDLE && call_req) || state == ST_CALL_HI ||
            (go && cur_kind == K_PUSH);
    sp_down = go && cur_kind == K_POP;
    sfr_wr = fin && sfr_hit && cur_we;
  end

  // Sequencer for multi-cycle accesses and answers to the core
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      kind_q <= K_DIRECT;
      ptr_q <= 8'h00;
      we_q <= 1'b0;
      wdata_q <= 8'h00;
      ret_hi_q <= 8'h00;
      acc_done <= 1'b0;
      acc_rdata <= 8'h00;
      acc_bit <= 1'b0;
    end else begin
      acc_done <= fin;
      if (fin && state != ST_CALL_HI) begin
        acc_rdata <= byte_rd;
        acc_bit <= byte_rd[bit_idx];
      end
      case (state)
        ST_IDLE: begin
          if (call_req) begin
            ret_hi_q <= call_ret_addr[15:8];
            state <= ST_CALL_HI;
          end else if (acc_req && need_ptr) begin
            ptr_q <= sp_bus.rdata;
            kind_q <= acc_kind;
            we_q <= acc_we;
            wdata_q <= acc_wdata;
            state <= ST_ACCESS;
          end
        end
        ST_ACCESS: state <= ST_IDLE;
        ST_CALL_HI: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Stack pointer, status word, base register and timed-access guard
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sp <= SP_RESET; // [R20]
      program_status_word <= PSW_RESET;
      df_base <= DFBASE_RESET;
      init_cnt <= INIT_CYCLES;
      guard_armed <= 1'b0;
      guard_cnt <= 3'h0;
    end else begin
      if (init_cnt != 2'h0) begin
        init_cnt <= init_cnt - 2'h1;
        df_base <= cfg2_s; // [R06]
      end
      if (guard_open) begin
        guard_cnt <= guard_cnt - 3'h1;
      end
      if (sp_up) begin
        sp <= sp + 8'h01; // [R21]
      end else if (sp_down) begin
        sp <= sp - 8'h01; // [R21]
      end
      if (sfr_wr) begin
        case (sfr_a)
          SFR_SP: sp <= sfr_wd; // [R20]
          SFR_PSW: program_status_word <= sfr_wd;
          SFR_DFBASE: begin
            if (guard_open && !SMALL_VARIANT && init_cnt == 2'h0) begin
              df_base <= sfr_wd; // [R08] [R09]
            end
            guard_cnt <= 3'h0;
          end
          SFR_GUARD: begin
            if (!guard_armed && sfr_wd == GUARD_KEY1) begin
              guard_armed <= 1'b1;
            end else if (guard_armed && sfr_wd == GUARD_KEY2) begin
              guard_armed <= 1'b0;
              guard_cnt <= 3'(GUARD_WINDOW_CYCLES);
            end else begin
              guard_armed <= 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Page erase requests and partition outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      erase_go <= 1'b0;
      erase_refused <= 1'b0;
      erase_page_base <= 16'h0000;
      df_start_addr <= FLASH_SIZE;
      app_limit_addr <= FLASH_SIZE;
    end else begin
      erase_go <= 1'b0;
      erase_refused <= 1'b0;
      df_start_addr <= map_df_start;
      app_limit_addr <= map_app_limit;
      if (erase_req) begin
        erase_page_base <= erase_addr & PAGE_MASK; // [R01]
        if (erase_config && !(boot_s || ext_s)) begin
          erase_refused <= 1'b1; // [R11]
        end else begin
          erase_go <= 1'b1;
        end
      end
    end
  end

  property p_sp_reset;
    @(posedge sys_clk) $fell(rst) |-> sp == SP_RESET;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("stack pointer not 07h after reset"); // [R20]

  property p_pc_wrap;
    @(posedge sys_clk) disable iff (rst)
      (fetch_step && !pc_load && prog_counter == PC_WRAP) |=> prog_counter == 16'h0000;
  endproperty
  a_pc_wrap: assert property (p_pc_wrap) else $error("counter did not wrap to zero"); // [R03]

  property p_boot_map;
    @(posedge sys_clk) disable iff (rst)
      fetch_boot |-> fetch_phys_addr == BOOT_FLASH_BASE + {5'h00, prog_counter[10:0]};
  endproperty
  a_boot_map: assert property (p_boot_map) else $error("boot region remap wrong"); // [R04]

  property p_page;
    @(posedge sys_clk) disable iff (rst)
      erase_req |=> erase_page_base == {$past(erase_addr[15:7]), 7'h00};
  endproperty
  a_page: assert property (p_page) else $error("erase base not page aligned"); // [R01]

  // The last reset load lands on the edge that empties the load counter
  property p_guard;
    @(posedge sys_clk) disable iff (rst)
      ($past(init_cnt) == 2'h0 && $changed(df_base)) |-> $past(guard_open);
  endproperty
  a_guard: assert property (p_guard) else $error("base changed outside window"); // [R08]

  property p_push;
    @(posedge sys_clk) disable iff (rst)
      (go && cur_kind == K_PUSH) |-> (sp_bus.we && sp_bus.addr == sp + 8'h01)
        ##1 (sp == $past(sp) + 8'h01 && acc_done);
  endproperty
  a_push: assert property (p_push) else $error("push order wrong"); // [R21]

  property p_call;
    @(posedge sys_clk) disable iff (rst)
      (state == ST_IDLE && call_req) |=> state == ST_CALL_HI ##1 (acc_done && state == ST_IDLE);
  endproperty
  a_call: assert property (p_call) else $error("call push sequence wrong"); // [R22]

  property p_bank;
    @(posedge sys_clk) disable iff (rst)
      (go && cur_kind == K_REG) |-> sp_bus.addr == {3'h0, program_status_word[4:3], cur_addr[2:0]};
  endproperty
  a_bank: assert property (p_bank) else $error("register bank mapping wrong"); // [R23]

  property p_stack_ram;
    @(posedge sys_clk) disable iff (rst)
      (go && (cur_kind == K_PUSH || cur_kind == K_POP)) |-> !xr_bus.we && !x_sel;
  endproperty
  a_stack_ram: assert property (p_stack_ram) else $error("stack routed to aux RAM"); // [R13]

  property p_indirect;
    @(posedge sys_clk) disable iff (rst)
      (go && (cur_kind == K_INDIRECT || cur_kind == K_XRI)) |-> !sfr_hit;
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect hit a register"); // [R14]
endmodule

// ---- bench/mmd_core_model.sv ----
// Processor-core model issuing data accesses and calls to the decoder
`timescale 1ns/1ps
module mmd_core_model
  import mmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic acc_done,
  input wire logic [7:0] acc_rdata,
  output logic acc_req,
  output mmd_kind_e acc_kind,
  output logic [7:0] acc_addr,
  output logic [7:0] acc_wdata,
  output logic acc_we,
  output logic call_req,
  output logic [15:0] call_ret_addr
);
  initial begin
    acc_req = 1'b0;
    acc_kind = K_DIRECT;
    acc_addr = 8'h00;
    acc_wdata = 8'h00;
    acc_we = 1'b0;
    call_req = 1'b0;
    call_ret_addr = 16'h0000;
  end

  // Hold the request until done is seen or eight rising edges pass, then release on the next falling edge
  task automatic wait_done(output logic [7:0] rd);
    rd = 'x;
    for (int n = 0; n < 8; n++) begin
      @(posedge sys_clk);
      #1;
      if (acc_done === 1'b1) begin
        rd = acc_rdata;
        break;
      end
    end
    @(negedge sys_clk);
    acc_req = 1'b0;
    call_req = 1'b0;
    // Address, write-data and return-address lines show their inverted last value; kind and write enable keep theirs
    acc_addr = ~acc_addr;
    acc_wdata = ~acc_wdata;
    call_ret_addr = ~call_ret_addr;
  endtask

  task automatic access(mmd_kind_e k, logic [7:0] a, logic [7:0] wd, logic we, int gap,
                        output logic [7:0] rd);
    repeat (gap) @(negedge sys_clk);
    @(negedge sys_clk);
    acc_req = 1'b1;
    acc_kind = k;
    acc_addr = a;
    acc_wdata = wd;
    acc_we = we;
    wait_done(rd);
  endtask

  task automatic call(logic [15:0] ret);
    logic [7:0] rd;
    @(negedge sys_clk);
    call_req = 1'b1;
    call_ret_addr = ret;
    wait_done(rd);
  endtask
endmodule

// ---- bench/mmd_decode_tb_top.sv ----
// Self-checking bench for the memory-map decode block
`timescale 1ns/1ps
module mmd_decode_tb_top
  import mmd_pkg::*;
;
  logic sys_clk, rst, boot_select_bit, ext_writer_active, fetch_step, pc_load;
  logic [7:0] config_byte_first, config_byte_second, acc_addr, acc_wdata, acc_rdata;
  logic [15:0] pc_load_value, prog_counter, fetch_phys_addr, call_ret_addr, erase_addr;
  logic [15:0] erase_page_base, df_start_addr, app_limit_addr, lim, ca, v;
  logic [15:0] sm_df_start, sm_app_limit;
  logic fetch_nop, fetch_boot, acc_req, acc_we, acc_done, acc_bit, call_req;
  logic erase_req, erase_config, erase_go, erase_refused;
  mmd_kind_e acc_kind;
  logic [7:0] base, rd, d, x, a;
  int errors, compares, gap_max;
  int ram[256];
  int aux_mem[256];
  int stk[$];

  mmd_decode #(.SMALL_VARIANT(1'b0)) i_dut (
    .sys_clk, .rst, .config_byte_first, .config_byte_second, .boot_select_bit,
    .ext_writer_active, .fetch_step, .pc_load, .pc_load_value, .prog_counter,
    .fetch_phys_addr, .fetch_nop, .fetch_boot, .acc_req, .acc_kind, .acc_addr,
    .acc_wdata, .acc_we, .acc_done, .acc_rdata, .acc_bit, .call_req, .call_ret_addr,
    .erase_req, .erase_addr, .erase_config, .erase_go, .erase_page_base,
    .erase_refused, .df_start_addr, .app_limit_addr
  );
  // Small variant sees the same stimulus; only its partition is watched
  mmd_decode #(.SMALL_VARIANT(1'b1)) i_dut_small (
    .sys_clk, .rst, .config_byte_first, .config_byte_second, .boot_select_bit,
    .ext_writer_active, .fetch_step, .pc_load, .pc_load_value, .prog_counter(),
    .fetch_phys_addr(), .fetch_nop(), .fetch_boot(), .acc_req, .acc_kind, .acc_addr,
    .acc_wdata, .acc_we, .acc_done(), .acc_rdata(), .acc_bit(), .call_req, .call_ret_addr,
    .erase_req, .erase_addr, .erase_config, .erase_go(), .erase_page_base(),
    .erase_refused(), .df_start_addr(sm_df_start), .app_limit_addr(sm_app_limit)
  );
  mmd_core_model i_core (
    .sys_clk, .acc_done, .acc_rdata, .acc_req, .acc_kind, .acc_addr, .acc_wdata,
    .acc_we, .call_req, .call_ret_addr
  );

  initial begin
    sys_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // One access; a non-negative expectation is compared with the read byte
  task automatic acc(mmd_kind_e k, logic [7:0] ad, logic [7:0] wd, logic we, int exp);
    i_core.access(k, ad, wd, we, $urandom_range(gap_max), rd);
    if (exp >= 0) chk($sformatf("%s read at %h", k.name(), ad), exp[15:0], {8'h00, rd});
  endtask

  task automatic fetch(logic ld, logic [15:0] val, logic [15:0] exp_pc);
    logic nop;
    nop = boot_select_bit ? (exp_pc >= BOOT_FLASH_SIZE) : (exp_pc >= lim);
    cyc(1);
    pc_load = ld;
    pc_load_value = val;
    fetch_step = ~ld;
    cyc(1);
    pc_load = 1'b0;
    fetch_step = 1'b0;
    chk("prog_counter", exp_pc, prog_counter);
    chk("fetch_nop", {15'h0, nop}, {15'h0, fetch_nop});
    chk("fetch_phys", exp_pc + (boot_select_bit ? BOOT_FLASH_BASE : 16'h0), fetch_phys_addr);
    chk("fetch_boot", {15'h0, boot_select_bit}, {15'h0, fetch_boot});
  endtask

  task automatic erase(logic [15:0] ea, logic cfg, logic go);
    cyc(1);
    erase_req = 1'b1;
    erase_addr = ea;
    erase_config = cfg;
    cyc(1);
    erase_req = 1'b0;
    erase_addr = ~ea;
    chk("erase_go", {15'h0, go}, {15'h0, erase_go});
    chk("erase_refused", {15'h0, ~go}, {15'h0, erase_refused});
    if (go) chk("erase_page", (ea / 128) * 128, erase_page_base);
  endtask

  task automatic do_reset();
    rst = 1'b1;
    cyc(20);
    rst = 1'b0;
    cyc(6);
    base = config_byte_second;
    lim = {base, 8'h00};
    stk.delete();
  endtask

  // Whole sequence needs well under 2000 cycles
  initial begin
    #(CLK_PERIOD_NS * 20000);
    errors++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h6e56_963a));
    errors = 0;
    compares = 0;
    gap_max = 1;
    rst = 1'b1;
    config_byte_first = 8'h00;
    config_byte_second = 8'h28;
    boot_select_bit = 1'b0;
    ext_writer_active = 1'b0;
    fetch_step = 1'b0;
    pc_load = 1'b0;
    pc_load_value = 16'h0000;
    erase_req = 1'b0;
    erase_addr = 16'h0000;
    erase_config = 1'b0;
    do_reset();
    chk("prog_counter", RESET_VECTOR, prog_counter);
    chk("df_start", {base, 8'h00}, df_start_addr);
    chk("app_limit", {base, 8'h00}, app_limit_addr);
    chk("small_df_start", SMALL_DF_START, sm_df_start);
    chk("small_app_limit", SMALL_APP_LIMIT, sm_app_limit);
    acc(K_DIRECT, SFR_SP, 8'h00, 1'b0, SP_RESET);
    fetch(1'b1, 16'h3FFE, 16'h3FFE);
    fetch(1'b0, 16'h0000, PC_WRAP);
    fetch(1'b0, 16'h0000, 16'h0000);
    v = 16'($urandom_range(32'h27FE));
    fetch(1'b1, v, v);
    fetch(1'b0, 16'h0000, v + 16'h0001);
    for (int i = 0; i < 4; i++) erase(16'($urandom_range(32'h3FFF)), 1'b0, 1'b1);
    erase(16'h3FFF, 1'b0, 1'b1);
    erase(16'h1234, 1'b1, 1'b0);
    ext_writer_active = 1'b1;
    cyc(4);
    erase(16'h1234, 1'b1, 1'b1);
    ext_writer_active = 1'b0;
    boot_select_bit = 1'b1;
    cyc(4);
    erase(16'h0000, 1'b1, 1'b1);
    fetch(1'b1, 16'h0010, 16'h0010);
    boot_select_bit = 1'b0;
    cyc(4);
    d = 8'h10 + 8'($urandom_range(8'h17));
    acc(K_DIRECT, SFR_DFBASE, d, 1'b1, -1);
    acc(K_DIRECT, SFR_DFBASE, 8'h00, 1'b0, base);
    gap_max = 0;
    acc(K_DIRECT, SFR_GUARD, GUARD_KEY1, 1'b1, -1);
    acc(K_DIRECT, SFR_GUARD, GUARD_KEY2, 1'b1, -1);
    acc(K_DIRECT, SFR_DFBASE, d, 1'b1, -1);
    gap_max = 2;
    base = d;
    cyc(3);
    acc(K_DIRECT, SFR_DFBASE, 8'h00, 1'b0, base);
    chk("df_start", {base, 8'h00}, df_start_addr);
    chk("app_limit", {base, 8'h00}, app_limit_addr);
    chk("small_df_start", SMALL_DF_START, sm_df_start);
    config_byte_first = 8'h01;
    cyc(5);
    chk("app_limit", FLASH_SIZE, app_limit_addr);
    chk("df_start", FLASH_SIZE, df_start_addr);
    chk("small_df_start", FLASH_SIZE, sm_df_start);
    config_byte_first = 8'h00;
    config_byte_second = 8'h1C;
    do_reset();
    chk("df_start", {base, 8'h00}, df_start_addr);
    acc(K_DIRECT, SFR_SP, 8'h00, 1'b0, SP_RESET);
    for (int b = 0; b < 4; b++) begin
      d = 8'($urandom);
      acc(K_DIRECT, SFR_PSW, 8'(b << PSW_RS_LSB), 1'b1, -1);
      acc(K_REG, 8'(b + 2), d, 1'b1, -1);
      ram[b * 9 + 2] = d;
      acc(K_DIRECT, 8'(b * 9 + 2), 8'h00, 1'b0, ram[b * 9 + 2]);
    end
    acc(K_DIRECT, SFR_PSW, PSW_RESET, 1'b1, -1);
    acc(K_BIT, 8'hD3, 8'h01, 1'b1, -1);
    acc(K_REG, 8'h03, 8'h00, 1'b0, ram[11]);
    acc(K_DIRECT, SFR_PSW, PSW_RESET, 1'b1, -1);
    d = 8'($urandom);
    acc(K_REG, 8'h00, SFR_DFBASE, 1'b1, -1);
    acc(K_INDIRECT, 8'h00, d, 1'b1, -1);
    acc(K_DIRECT, SFR_DFBASE, 8'h00, 1'b0, base);
    acc(K_INDIRECT, 8'h00, 8'h00, 1'b0, d);
    x = 8'h40 + 8'($urandom_range(8'hBF));
    ram[x] = 8'($urandom);
    aux_mem[x] = 8'(~ram[x]);
    acc(K_REG, 8'h01, x, 1'b1, -1);
    acc(K_INDIRECT, 8'h01, 8'(ram[x]), 1'b1, -1);
    acc(K_XRI, 8'h01, 8'(aux_mem[x]), 1'b1, -1);
    acc(K_XDPTR, x, 8'h00, 1'b0, aux_mem[x]);
    acc(K_INDIRECT, 8'h01, 8'h00, 1'b0, ram[x]);
    acc(K_DIRECT, SFR_SP, 8'h30, 1'b1, -1);
    d = 8'($urandom);
    acc(K_PUSH, 8'h00, d, 1'b1, -1);
    stk.push_back(d);
    acc(K_DIRECT, 8'h31, 8'h00, 1'b0, d);
    acc(K_DIRECT, SFR_SP, 8'h00, 1'b0, 8'h31);
    ca = 16'($urandom);
    i_core.call(ca);
    stk.push_back(ca[7:0]);
    stk.push_back(ca[15:8]);
    acc(K_DIRECT, 8'h32, 8'h00, 1'b0, ca[7:0]);
    acc(K_DIRECT, SFR_SP, 8'h00, 1'b0, 8'h33);
    repeat (3) acc(K_POP, 8'h00, 8'h00, 1'b0, stk.pop_back());
    acc(K_DIRECT, SFR_SP, 8'h00, 1'b0, 8'h30);
    for (int i = 0; i < 4; i++) begin
      a = 8'($urandom_range(8'h7F));
      d = 8'($urandom);
      acc(K_DIRECT, BIT_RAM_BASE + (a >> 3), d, 1'b1, -1);
      acc(K_BIT, a, 8'(i & 1), 1'b1, d);
      chk("acc_bit", {15'h0, d[a[2:0]]}, {15'h0, acc_bit});
      d[a[2:0]] = i[0];
      acc(K_DIRECT, BIT_RAM_BASE + (a >> 3), 8'h00, 1'b0, d);
    end
    finish_test();
  end
endmodule
